// >>> logic/bacr_top.sv
// Contract
// - Commands 26h and 32h write low sense thresholds of channels 1 and 2.
// - Commands A6h and B2h read back the low sense thresholds.
// - Commands 28h and 34h write high gate thresholds of channels 1 and 2.
// - Commands A8h and B4h read back the high gate thresholds.
// - Commands 2Ah and 36h write low gate thresholds of channels 1 and 2.
// - Commands AAh and B6h read back the low gate thresholds.
// - Thresholds keep data bits 11 to 0; the upper four bits are ignored.
// - Sense and gate thresholds are unsigned straight binary, both directions.
// - Sense code all ones equals a quarter of the DAC reference, zero is 0 mV.
// - High sense thresholds reset to all ones.
// - Low sense thresholds reset to all zeros.
// - High gate thresholds reset to all ones.
// - Low gate thresholds reset to all zeros.
// - Hardware configuration written with 38h, read with B8h; upper four bits ignored.
// - Bits 11:10 and 9:8 set gate ceilings of channels 2 and 1; reset zero.
// - Ceiling codes give ground plus 0, 250, 500 or 750 mV.
// - Monitor bit 6 set lets ADC results into the FIFO; clear keeps them out.
// - Monitor bit never gates alarm checking or DAC code recalculation.
// - Bits 5:4 choose conversion clock and start pin mode; reset 00.
// - Mode 00 register start, 01 one low pulse of 20 ns, 10 reserved, 11 per pulse.
// - Bits 3:2 choose the ADC reference; reset 00.
// - ADC reference upper bit 0 is external, 10 and 11 internal.
// - Bits 1:0 choose the DAC reference; reset 00.
// - DAC reference upper bit 0 is external, 10 and 11 internal.
// - Software configuration written with 3Ah, read with BAh.
// - Software configuration sets DAC load target and lookup modes per channel.
`timescale 1ns/1ps
`include "bacr_defs.svh"

module bacr_top (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  // Serial link
  input  wire logic              spi_sclk_i,
  input  wire logic              spi_cs_n_i,
  input  wire logic              spi_mosi_i,
  output logic                   spi_miso_o,
  output logic                   spi_miso_oe_o,
  // Conversion start
  input  wire logic              conversion_start_pin_n_i,
  input  wire logic              conv_reg_write_i,
  output logic                   conv_start_o,
  output logic                   acquire_o,
  // ADC results
  input  wire logic              adc_result_valid_i,
  input  wire logic [15:0]       adc_result_i,
  output logic                   fifo_push_o,
  output logic                   alarm_check_valid_o,
  output logic                   dac_recalc_valid_o,
  output logic [15:0]            adc_data_o,
  // Configuration
  input  wire logic [11:0]       dac_reference_voltage_i,
  output bacr_pkg::bacr_thr_s    thr_ch1_o,
  output bacr_pkg::bacr_thr_s    thr_ch2_o,
  output bacr_pkg::bacr_hwc_s    hwcfg_o,
  output bacr_pkg::bacr_swc_s    swcfg_o,
  output logic [9:0]             gate1_ceiling_mv_o,
  output logic [9:0]             gate2_ceiling_mv_o,
  output logic [11:0]            sense_hi_ch1_mv_o,
  output logic [11:0]            sense_hi_ch2_mv_o,
  output logic                   adc_ref_internal_o,
  output logic                   dac_ref_internal_o
);

  localparam logic [3:0] IDX_HSNS1  = 4'h0;
  localparam logic [3:0] IDX_LSNS1  = 4'h1;
  localparam logic [3:0] IDX_HGATE1 = 4'h2;
  localparam logic [3:0] IDX_LGATE1 = 4'h3;
  localparam logic [3:0] IDX_HSNS2  = 4'h4;
  localparam logic [3:0] IDX_LSNS2  = 4'h5;
  localparam logic [3:0] IDX_HGATE2 = 4'h6;
  localparam logic [3:0] IDX_LGATE2 = 4'h7;
  localparam logic [3:0] IDX_HWCFG  = 4'h8;
  localparam logic [3:0] IDX_SWCFG  = 4'h9;
  localparam int         NREGS      = 10;

  localparam int unsigned PULSE_CYC   = (`BACR_CONV_PULSE_NS + `BACR_CLK_PERIOD_NS - 1) / `BACR_CLK_PERIOD_NS;
  localparam logic [2:0]  PULSE_CYC_W = 3'(PULSE_CYC);

  // Command to register index, top bit marks a known command
  function automatic logic [4:0] cmd_index(input logic [6:0] c);
    case (c)
      `BACR_CMD_HSNS1:  cmd_index = {1'b1, IDX_HSNS1};
      `BACR_CMD_LSNS1:  cmd_index = {1'b1, IDX_LSNS1};
      `BACR_CMD_HGATE1: cmd_index = {1'b1, IDX_HGATE1};
      `BACR_CMD_LGATE1: cmd_index = {1'b1, IDX_LGATE1};
      `BACR_CMD_HSNS2:  cmd_index = {1'b1, IDX_HSNS2};
      `BACR_CMD_LSNS2:  cmd_index = {1'b1, IDX_LSNS2};
      `BACR_CMD_HGATE2: cmd_index = {1'b1, IDX_HGATE2};
      `BACR_CMD_LGATE2: cmd_index = {1'b1, IDX_LGATE2};
      `BACR_CMD_HWCFG:  cmd_index = {1'b1, IDX_HWCFG};
      `BACR_CMD_SWCFG:  cmd_index = {1'b1, IDX_SWCFG};
      default:          cmd_index = 5'h00;
    endcase
  endfunction

  // Power-on value of each register
  function automatic logic [11:0] rst_val(input int i);
    case (i)
      0, 2, 4, 6: rst_val = `BACR_RST_ONES;
      1, 3, 5, 7: rst_val = `BACR_RST_ZERO;
      default:    rst_val = `BACR_RST_CFG;
    endcase
  endfunction

  function automatic logic [9:0] ceil_mv(input logic [1:0] c);
    ceil_mv = 10'(c * `BACR_CEIL_STEP_MV);
  endfunction

  // Unsigned code to millivolts, all ones lands on reference / 4
  function automatic logic [11:0] sense_mv(input logic [11:0] vref, input logic [11:0] code);
    logic [24:0] p;
    p = 25'(vref) * 25'({1'b0, code} + 13'h0001);
    sense_mv = {1'b0, p[24:`BACR_SENSE_SHIFT]};
  endfunction

  // Synchronisers
  logic sclk_s1_r, sclk_s2_r, sclk_d_r;
  logic cs_s1_r, cs_s2_r;
  logic mosi_s1_r, mosi_s2_r;
  logic cnv_s1_r, cnv_s2_r, cnv_d_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {sclk_s1_r, sclk_s2_r, sclk_d_r} <= 3'h0;
      {cs_s1_r, cs_s2_r}               <= 2'h3;
      {mosi_s1_r, mosi_s2_r}           <= 2'h0;
      {cnv_s1_r, cnv_s2_r, cnv_d_r}    <= 3'h7;
    end else begin
      {sclk_s1_r, sclk_s2_r, sclk_d_r} <= {spi_sclk_i, sclk_s1_r, sclk_s2_r};
      {cs_s1_r, cs_s2_r}               <= {spi_cs_n_i, cs_s1_r};
      {mosi_s1_r, mosi_s2_r}           <= {spi_mosi_i, mosi_s1_r};
      {cnv_s1_r, cnv_s2_r, cnv_d_r}    <= {conversion_start_pin_n_i, cnv_s1_r, cnv_s2_r};
    end
  end

  wire sclk_rise = sclk_s2_r & ~sclk_d_r;
  wire sclk_fall = ~sclk_s2_r & sclk_d_r;
  wire selected  = ~cs_s2_r;

  // Frame state
  bacr_pkg::bacr_state_e state_r, state_nxt;
  logic [4:0]  bit_cnt_r;
  logic [14:0] sh_r;
  logic [7:0]  cmd_r;
  logic [15:0] tx_r;
  logic [11:0] regs_r [0:NREGS-1];

  wire        spi_mosi_bit = mosi_s2_r;
  wire [7:0]  cmd_word   = {sh_r[6:0], spi_mosi_bit};
  wire [4:0]  rd_sel     = cmd_index(cmd_word[6:0]);
  wire [4:0]  wr_sel     = cmd_index(cmd_r[6:0]);
  wire        cmd_done   = (state_r == bacr_pkg::BACR_ST_CMD) && sclk_rise && (bit_cnt_r == `BACR_CMD_BITS - 5'h01);
  wire        data_done  = (state_r == bacr_pkg::BACR_ST_DATA) && sclk_rise && (bit_cnt_r == `BACR_FRAME_BITS - 5'h01);
  wire        is_read    = cmd_r[`BACR_CMD_RD_BIT];
  wire        wr_en      = data_done && !is_read && wr_sel[4];
  wire [11:0] wr_data    = {sh_r[10:0], spi_mosi_bit};
  wire [15:0] rd_word    = rd_sel[4] ? {4'h0, regs_r[rd_sel[3:0]]} : 16'h0000;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      bacr_pkg::BACR_ST_IDLE: if (selected) state_nxt = bacr_pkg::BACR_ST_CMD;
      bacr_pkg::BACR_ST_CMD:  if (cmd_done) state_nxt = bacr_pkg::BACR_ST_DATA;
      bacr_pkg::BACR_ST_DATA: if (data_done) state_nxt = bacr_pkg::BACR_ST_DONE;
      bacr_pkg::BACR_ST_DONE: state_nxt = bacr_pkg::BACR_ST_DONE;
    endcase
    if (!selected) state_nxt = bacr_pkg::BACR_ST_IDLE;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r   <= bacr_pkg::BACR_ST_IDLE;
      bit_cnt_r <= 5'h00;
      sh_r      <= 15'h0000;
      cmd_r     <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (!selected) begin
        bit_cnt_r <= 5'h00;
      end else if (sclk_rise && state_r != bacr_pkg::BACR_ST_DONE) begin
        bit_cnt_r <= 5'(bit_cnt_r + 5'h01);
        sh_r      <= {sh_r[13:0], spi_mosi_bit};
      end
      if (cmd_done) begin
        cmd_r <= cmd_word;
      end
    end
  end

  // Read data shifts out MSB first on falling clock
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_r          <= 16'h0000;
      spi_miso_o    <= 1'b0;
      spi_miso_oe_o <= 1'b0;
    end else if (!selected) begin
      spi_miso_o    <= 1'b0;
      spi_miso_oe_o <= 1'b0;
    end else if (cmd_done && cmd_word[`BACR_CMD_RD_BIT]) begin
      tx_r          <= rd_word;
      spi_miso_oe_o <= 1'b1;
    end else if (sclk_fall && state_r == bacr_pkg::BACR_ST_DATA && is_read) begin
      spi_miso_o <= tx_r[15];
      tx_r       <= {tx_r[14:0], 1'b0};
    end
  end

  // Register file
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NREGS; i++) begin
        regs_r[i] <= rst_val(i);
      end
    end else begin
      for (int i = 0; i < NREGS; i++) begin
        if (wr_en && wr_sel[3:0] == 4'(i)) begin
          regs_r[i] <= wr_data;
        end
      end
    end
  end

  assign thr_ch1_o = {regs_r[IDX_HSNS1], regs_r[IDX_LSNS1], regs_r[IDX_HGATE1], regs_r[IDX_LGATE1]};
  assign thr_ch2_o = {regs_r[IDX_HSNS2], regs_r[IDX_LSNS2], regs_r[IDX_HGATE2], regs_r[IDX_LGATE2]};
  assign hwcfg_o   = {regs_r[IDX_HWCFG][11:8], regs_r[IDX_HWCFG][6:0]};
  assign swcfg_o   = regs_r[IDX_SWCFG];

  wire [11:0] hwcfg_w = regs_r[IDX_HWCFG];
  wire        mon_en  = hwcfg_w[`BACR_HWC_MON_BIT];
  wire [1:0]  ck_mode = hwcfg_w[`BACR_HWC_CKM_LSB +: 2];

  // References pick internal only when the upper bit is set
  assign adc_ref_internal_o = hwcfg_w[`BACR_HWC_AREF_LSB + 1];
  assign dac_ref_internal_o = hwcfg_w[`BACR_HWC_DREF_LSB + 1];

  // Derived limits
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gate1_ceiling_mv_o <= 10'h000;
      gate2_ceiling_mv_o <= 10'h000;
      sense_hi_ch1_mv_o  <= 12'h000;
      sense_hi_ch2_mv_o  <= 12'h000;
    end else begin
      gate1_ceiling_mv_o <= ceil_mv(hwcfg_w[`BACR_HWC_CEIL1_LSB +: 2]);
      gate2_ceiling_mv_o <= ceil_mv(hwcfg_w[`BACR_HWC_CEIL2_LSB +: 2]);
      sense_hi_ch1_mv_o  <= sense_mv(dac_reference_voltage_i, regs_r[IDX_HSNS1]);
      sense_hi_ch2_mv_o  <= sense_mv(dac_reference_voltage_i, regs_r[IDX_HSNS2]);
    end
  end

  // ADC result routing
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fifo_push_o         <= 1'b0;
      alarm_check_valid_o <= 1'b0;
      dac_recalc_valid_o  <= 1'b0;
      adc_data_o          <= 16'h0000;
    end else begin
      fifo_push_o         <= adc_result_valid_i & mon_en;
      alarm_check_valid_o <= adc_result_valid_i;
      dac_recalc_valid_o  <= adc_result_valid_i;
      adc_data_o          <= adc_result_i;
    end
  end

  // Conversion start handling
  logic [2:0] low_cnt_r;
  wire        cnv_rise  = cnv_s2_r & ~cnv_d_r;
  wire        pulse_ok  = low_cnt_r >= PULSE_CYC_W;
  wire        start_reg = (ck_mode == bacr_pkg::BACR_CKM_REG_WRITE) && conv_reg_write_i;
  wire        start_one = (ck_mode == bacr_pkg::BACR_CKM_PIN_ONCE) && cnv_rise && pulse_ok;
  wire        start_each = (ck_mode == bacr_pkg::BACR_CKM_PIN_EACH) && cnv_rise;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_cnt_r    <= 3'h0;
      conv_start_o <= 1'b0;
      acquire_o    <= 1'b0;
    end else begin
      if (cnv_s2_r) begin
        low_cnt_r <= 3'h0;
      end else if (!pulse_ok) begin
        low_cnt_r <= 3'(low_cnt_r + 3'h1);
      end
      conv_start_o <= start_reg | start_one | start_each;
      acquire_o    <= (ck_mode == bacr_pkg::BACR_CKM_PIN_EACH) && !cnv_s2_r;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_fifo_gate: assert property (adc_result_valid_i |=> fifo_push_o == $past(mon_en))
    else $error("fifo push does not follow monitor bit");
  a_alarm_always: assert property (adc_result_valid_i |=> alarm_check_valid_o && dac_recalc_valid_o)
    else $error("alarm or recalc path gated");
  a_lsns1_write: assert property (wr_en && cmd_r[6:0] == `BACR_CMD_LSNS1 |=> regs_r[IDX_LSNS1] == $past(wr_data))
    else $error("low sense ch1 write lost");
  a_hgate2_write: assert property (wr_en && cmd_r[6:0] == `BACR_CMD_HGATE2 |=> regs_r[IDX_HGATE2] == $past(wr_data))
    else $error("high gate ch2 write lost");
  a_lgate1_write: assert property (wr_en && cmd_r[6:0] == `BACR_CMD_LGATE1 |=> thr_ch1_o.low_gate == $past(wr_data))
    else $error("low gate ch1 write lost");
  a_read_load: assert property (cmd_done && cmd_word[7] && rd_sel[4] |=> tx_r == {4'h0, regs_r[$past(rd_sel[3:0])]})
    else $error("read word wrong");
  a_read_upper: assert property (cmd_done && cmd_word[7] |=> tx_r[15:12] == 4'h0)
    else $error("don't care bits not zero");
  a_read_no_write: assert property (data_done && is_read |=> $stable(regs_r[IDX_HWCFG]) && $stable(regs_r[IDX_SWCFG]))
    else $error("read frame changed configuration");
  a_ceiling_mv: assert property (##1 gate1_ceiling_mv_o == 10'($past(hwcfg_w[9:8]) * 10'h0FA))
    else $error("gate ceiling value wrong");
  a_short_pulse: assert property (ck_mode == 2'b01 && cnv_rise && low_cnt_r < PULSE_CYC_W && !conv_reg_write_i
    |=> !conv_start_o)
    else $error("short start pulse accepted");
  a_reserved_mode: assert property (ck_mode == 2'b10 |=> !conv_start_o && !acquire_o)
    else $error("reserved mode started conversion");
  a_ref_decode: assert property (hwcfg_w[3] == 1'b0 |-> !adc_ref_internal_o)
    else $error("ADC reference decode wrong");
  a_reset_values: assert property (@(posedge clk_i) $fell(sys_rst_i) |-> regs_r[IDX_HSNS1] == `BACR_RST_ONES
    && regs_r[IDX_LSNS2] == `BACR_RST_ZERO && regs_r[IDX_HGATE1] == `BACR_RST_ONES
    && regs_r[IDX_LGATE2] == `BACR_RST_ZERO && regs_r[IDX_HWCFG] == `BACR_RST_CFG)
    else $error("power-on values wrong");
  a_oe_idle: assert property (!selected |=> !spi_miso_oe_o && !spi_miso_o)
    else $error("data out driven while deselected");
  a_sense_scale: assert property (regs_r[IDX_HSNS1] == 12'hFFF
    |=> sense_hi_ch1_mv_o == ($past(dac_reference_voltage_i) >> 2))
    else $error("full scale sense not a quarter of reference");

  c_write_frame: cover property (wr_en);
  c_read_frame: cover property (cmd_done && cmd_word[7] && rd_sel[4]);
  c_fifo_push: cover property (fifo_push_o);
  c_pin_each: cover property (start_each);
  c_short_reject: cover property (ck_mode == 2'b01 && cnv_rise && !pulse_ok);

endmodule

// >>> common/bacr_defs.svh
`ifndef BACR_DEFS_SVH
`define BACR_DEFS_SVH

// Command bytes, low seven bits; bit 7 set means read
`define BACR_CMD_RD_BIT      7
`define BACR_CMD_HSNS1       7'h24
`define BACR_CMD_LSNS1       7'h26
`define BACR_CMD_HGATE1      7'h28
`define BACR_CMD_LGATE1      7'h2A
`define BACR_CMD_HSNS2       7'h30
`define BACR_CMD_LSNS2       7'h32
`define BACR_CMD_HGATE2      7'h34
`define BACR_CMD_LGATE2      7'h36
`define BACR_CMD_HWCFG       7'h38
`define BACR_CMD_SWCFG       7'h3A

// Frame layout
`define BACR_CMD_BITS        5'h08
`define BACR_FRAME_BITS      5'h18
`define BACR_DATA_BITS       12

// Reset values
`define BACR_RST_ONES        12'hFFF
`define BACR_RST_ZERO        12'h000
`define BACR_RST_CFG         12'h000

// Hardware configuration field positions
`define BACR_HWC_CEIL2_LSB   10
`define BACR_HWC_CEIL1_LSB   8
`define BACR_HWC_MON_BIT     6
`define BACR_HWC_CKM_LSB     4
`define BACR_HWC_AREF_LSB    2
`define BACR_HWC_DREF_LSB    0

// Software configuration field positions
`define BACR_SWC_LOAD2_BIT   11
`define BACR_SWC_TLUT2_LSB   9
`define BACR_SWC_KLUT2_LSB   6
`define BACR_SWC_LOAD1_BIT   5
`define BACR_SWC_TLUT1_LSB   3
`define BACR_SWC_KLUT1_LSB   0

// Gate ceiling step and sense scale shift
`define BACR_CEIL_STEP_MV    10'h0FA
`define BACR_SENSE_SHIFT     14

// Timing
`define BACR_CLK_PERIOD_NS   5
`define BACR_CONV_PULSE_NS   20

`endif

// >>> common/bacr_pkg.sv
package bacr_pkg;

  typedef enum logic [1:0] {
    BACR_ST_IDLE = 2'b00,
    BACR_ST_CMD  = 2'b01,
    BACR_ST_DATA = 2'b10,
    BACR_ST_DONE = 2'b11
  } bacr_state_e;

  typedef enum logic [1:0] {
    BACR_CKM_REG_WRITE = 2'b00,
    BACR_CKM_PIN_ONCE  = 2'b01,
    BACR_CKM_RESERVED  = 2'b10,
    BACR_CKM_PIN_EACH  = 2'b11
  } bacr_ckmode_e;

  typedef struct packed {
    logic [11:0] high_sense;
    logic [11:0] low_sense;
    logic [11:0] high_gate;
    logic [11:0] low_gate;
  } bacr_thr_s;

  typedef struct packed {
    logic [1:0] gate2_ceiling;
    logic [1:0] gate1_ceiling;
    logic       adc_monitor_enable;
    logic [1:0] conv_clock_mode;
    logic [1:0] adc_ref_select;
    logic [1:0] dac_ref_select;
  } bacr_hwc_s;

  typedef struct packed {
    logic       load_through_ch2;
    logic [1:0] temp_lut_ch2;
    logic [2:0] k_src_ch2;
    logic       load_through_ch1;
    logic [1:0] temp_lut_ch1;
    logic [2:0] k_src_ch1;
  } bacr_swc_s;

endpackage

// >>> tb/bacr_host_model.sv
`timescale 1ns/1ps

module bacr_host_model (
  // Clock
  input  wire logic clk_i,
  // Serial link
  input  wire logic spi_miso_i,
  output logic      spi_sclk_o = 1'b0,
  output logic      spi_cs_n_o = 1'b1,
  output logic      spi_mosi_o = 1'b0
);

  // Frame of command byte then data word, MSB first; nbits below 24 aborts
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int half, input int nbits,
                      output logic [15:0] rd);
    logic [23:0] frame;
    frame = {cmd, wd};
    rd = 16'h0000;
    @(posedge clk_i);
    spi_cs_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 23; i >= 24 - nbits; i--) begin
      spi_mosi_o <= frame[i];
      repeat (half - 1) @(posedge clk_i);
      @(negedge clk_i);
      if (i < 16) rd[i] = spi_miso_i;
      @(posedge clk_i);
      spi_sclk_o <= 1'b1;
      repeat (half) @(posedge clk_i);
      spi_sclk_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    spi_cs_n_o <= 1'b1;
    spi_mosi_o <= ~spi_mosi_o;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// >>> tb/test_bias_alarm_config_registers.sv
`timescale 1ns/1ps

module test_bias_alarm_config_registers;
  logic                 clk_i = 1'b0;
  logic                 sys_rst_i = 1'b1;
  logic                 sclk, cs_n, mosi, miso, miso_oe;
  logic                 pin_n = 1'b1;
  logic                 reg_wr = 1'b0;
  logic                 res_vld = 1'b0;
  logic [15:0]          res_dat = 16'h0000;
  logic [11:0]          vref = 12'h9C4;
  logic                 conv_start, acquire, fifo_push, alarm_vld, recalc_vld;
  logic [15:0]          adc_data;
  bacr_pkg::bacr_thr_s  thr1, thr2;
  bacr_pkg::bacr_hwc_s  hwcfg;
  bacr_pkg::bacr_swc_s  swcfg;
  logic [9:0]           ceil1_mv, ceil2_mv;
  logic [11:0]          sns1_mv, sns2_mv;
  logic                 aref_int, dref_int;
  int                   failures = 0;
  int                   checked = 0;
  int                   starts = 0;
  int                   oe_cycles = 0;
  logic [7:0]           wcmd [10] = '{8'h24, 8'h26, 8'h28, 8'h2A, 8'h30, 8'h32, 8'h34, 8'h36, 8'h38, 8'h3A};

  always #2.5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (conv_start === 1'b1) starts++;
    if (miso_oe === 1'b1) oe_cycles++;
  end

  bacr_host_model u_host (.clk_i(clk_i), .spi_miso_i(miso), .spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi));

  bacr_top u_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .conversion_start_pin_n_i(pin_n), .conv_reg_write_i(reg_wr),
    .conv_start_o(conv_start), .acquire_o(acquire), .adc_result_valid_i(res_vld), .adc_result_i(res_dat),
    .fifo_push_o(fifo_push), .alarm_check_valid_o(alarm_vld), .dac_recalc_valid_o(recalc_vld),
    .adc_data_o(adc_data), .dac_reference_voltage_i(vref), .thr_ch1_o(thr1), .thr_ch2_o(thr2), .hwcfg_o(hwcfg),
    .swcfg_o(swcfg), .gate1_ceiling_mv_o(ceil1_mv), .gate2_ceiling_mv_o(ceil2_mv), .sense_hi_ch1_mv_o(sns1_mv),
    .sense_hi_ch2_mv_o(sns2_mv), .adc_ref_internal_o(aref_int), .dac_ref_internal_o(dref_int));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Host speaks at the nominal rate or slower, chosen at random
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int nbits, output logic [15:0] rd);
    int o0;
    o0 = oe_cycles;
    u_host.xfer(cmd, wd, 16 + 8 * ($urandom % 2), nbits, rd);
    check("miso_oe", {15'h0000, cmd[7]}, {15'h0000, oe_cycles != o0});
    check("miso_oe_idle", 16'h0000, {15'h0000, miso_oe});
  endtask

  function automatic logic [11:0] rst_val(input logic [7:0] cmd);
    return (cmd inside {8'h24, 8'h28, 8'h30, 8'h34}) ? 12'hFFF : 12'h000;
  endfunction

  task automatic adc_try(input logic mon);
    logic [15:0] rd, d;
    d = 16'($urandom);
    xfer(8'h38, {9'h000, mon, 6'h00}, 24, rd);
    res_dat <= d;
    res_vld <= 1'b1;
    @(posedge clk_i);
    res_vld <= 1'b0;
    @(negedge clk_i);
    check("fifo_push", {15'h0000, mon}, {15'h0000, fifo_push});
    check("alarm_check", 16'h0001, {15'h0000, alarm_vld});
    check("dac_recalc", 16'h0001, {15'h0000, recalc_vld});
    check("adc_data", d, adc_data);
  endtask

  task automatic conv_try(input logic [1:0] mode, input int exp_n);
    logic [15:0] rd;
    logic        acq;
    int          s0;
    xfer(8'h38, {10'h000, mode, 4'h0}, 24, rd);
    s0 = starts;
    reg_wr <= 1'b1;
    @(posedge clk_i);
    reg_wr <= 1'b0;
    repeat (6) @(posedge clk_i);
    pin_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    pin_n <= 1'b1;
    repeat (10) @(posedge clk_i);
    pin_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    acq = acquire;
    @(posedge clk_i);
    pin_n <= 1'b1;
    repeat (30) @(posedge clk_i);
    check("conv_starts", 16'(exp_n), 16'(starts - s0));
    check("acquire", {15'h0000, mode == 2'b11}, {15'h0000, acq});
    $display("test conversion mode %0d done", mode);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #400us;
    failures++;
    $display("[ERR] watchdog expected done seen hang");
    finish_test();
  end

  initial begin
    logic [15:0] rd, wd;
    void'($urandom(31));
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check("sense_mv", {4'h0, vref >> 2}, {4'h0, sns1_mv});
    foreach (wcmd[i]) begin
      xfer(wcmd[i] | 8'h80, 16'h0000, 24, rd);
      check("reset_read", {4'h0, rst_val(wcmd[i])}, rd);
    end
    $display("test reset values done");
    foreach (wcmd[i]) begin
      wd = (i == 0) ? 16'hFFFF : 16'($urandom);
      xfer(wcmd[i], wd, 24, rd);
      xfer(wcmd[i] | 8'h80, 16'h0000, 24, rd);
      check("readback", {4'h0, wd[11:0]}, rd);
      if (i == 8) check("hw_fields", {5'h00, wd[11:8], wd[6:0]}, {5'h00, hwcfg});
      if (i == 9) check("sw_fields", {4'h0, wd[11:0]}, {4'h0, swcfg});
    end
    $display("test write and read back done");
    xfer(8'h26, 16'hFABC, 24, rd);
    xfer(8'h26, 16'h0555, 20, rd);
    check("abort_keep", 16'h0ABC, {4'h0, thr1.low_sense});
    xfer(8'hFF, 16'h0000, 24, rd);
    check("unknown_read", 16'h0000, rd);
    xfer(8'h30, 16'h0000, 24, rd);
    check("high_sense2", 16'h0000, {4'h0, thr2.high_sense});
    vref <= 12'($urandom);
    repeat (6) @(posedge clk_i);
    check("sense_full", {4'h0, vref >> 2}, {4'h0, sns1_mv});
    check("sense_zero", 16'h0000, {4'h0, sns2_mv});
    $display("test abort and scale done");
    for (int c = 0; c < 4; c++) begin
      wd = {4'h0, 2'(3 - c), 2'(c), 4'h0, 2'(c), 2'(c)};
      xfer(8'h38, wd, 24, rd);
      check("ceiling1_mv", 16'(c) * 16'h00FA, {6'h00, ceil1_mv});
      check("ceiling2_mv", 16'(3 - c) * 16'h00FA, {6'h00, ceil2_mv});
      check("ref_internal", {14'h0000, c[1], c[1]}, {14'h0000, aref_int, dref_int});
    end
    $display("test hardware fields done");
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check("reset_low_sense", 16'h0000, {4'h0, thr1.low_sense});
    xfer(8'hB8, 16'h0000, 24, rd);
    check("reset_hw_config", 16'h0000, rd);
    $display("test mid-run reset done");
    adc_try(1'b0);
    adc_try(1'b1);
    $display("test adc monitor done");
    conv_try(2'b00, 1);
    conv_try(2'b01, 1);
    conv_try(2'b10, 0);
    conv_try(2'b11, 2);
    finish_test();
  end
endmodule
